// ### logic/aoa_cfg.svh
// Constants of the address offset arithmetic unit.
// Assumes inclusion by bare name from the package, segment control and top design files.
`ifndef AOA_CFG_SVH
`define AOA_CFG_SVH
`define AOA_OFS_W      16
`define AOA_SEG_W      7
`define AOA_SHORT_W    8
`define AOA_ADDR_W     23
`define AOA_SEG_RESET  7'h00
`define AOA_SEGM_RESET 1'b1
`endif

// ### logic/aoa_pkg.sv
// Types of the address offset arithmetic unit.
// Assumes aoa_cfg.svh is on the include path.
`include "aoa_cfg.svh"
package aoa_pkg;
   typedef enum logic [2:0] {
      AOA_MODE_INDEXED,
      AOA_MODE_RELATIVE,
      AOA_MODE_BASED,
      AOA_MODE_BASED_INDEXED,
      AOA_MODE_AUTOINC,
      AOA_MODE_AUTODEC,
      AOA_MODE_DIRECT
   } aoa_mode_type;
   typedef enum logic {
      AOA_SPACE_MEM,
      AOA_SPACE_IO
   } aoa_space_type;
endpackage

// ### logic/aoa_add_if.sv
// Interface between the address unit and its offset adder.
// Assumes a single clock domain; the adder is purely combinational.
`timescale 1ns/1ps
interface aoa_add_if;
   logic [15:0] op_a;
   logic [15:0] op_b;
   logic        sub;
   logic [15:0] sum;
   modport user  (output op_a, output op_b, output sub, input sum);
   modport adder (input op_a, input op_b, input sub, output sum);
endinterface

// ### logic/aoa_offset_adder.sv
// Sixteen-bit offset adder that wraps modulo 65536.
// Assumes operands are stable within the cycle.
`timescale 1ns/1ps
module aoa_offset_adder (
   aoa_add_if.adder bus
);
   logic [16:0] full;
   always_comb begin
      // Bit 16 is dropped: no carry or overflow leaves.
      if (bus.sub) begin
         full = {1'b0, bus.op_a} - {1'b0, bus.op_b};
      end else begin
         full = {1'b0, bus.op_a} + {1'b0, bus.op_b};
      end
      bus.sum = full[15:0];
   end
endmodule

// ### logic/aoa_seg_ctl.sv
// Segmentation mode flag, loaded by status or control loads and set by trap start.
// Assumes the sequencer pulses its load and trap inputs for one cycle.
`timescale 1ns/1ps
`include "aoa_cfg.svh"
module aoa_seg_ctl (
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_load_program_status_instr,
   input  wire logic       i_load_control_register_instr,
   input  wire logic       i_segm_value,
   input  wire logic       i_trap_start,
   output logic            o_segm
);
   typedef struct packed {
      logic segm;
   } aoa_segst_type;
   aoa_segst_type st;
   aoa_segst_type next_st;
   always_comb begin
      next_st = st;
      if (i_trap_start) begin
         next_st.segm = 1'b1;
      end else if (i_load_program_status_instr ||
                   i_load_control_register_instr) begin
         next_st.segm = i_segm_value;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st.segm <= `AOA_SEGM_RESET;
      end else begin
         st <= next_st;
      end
   end
   assign o_segm = st.segm;
endmodule

// ### logic/aoa_top.sv
// Address offset arithmetic unit: forms effective addresses.
// Assumes the sequencer presents one request per cycle on I_REQ.
// Function
// - Without segmentation every memory address is a 16-bit value; here the PC segment is still joined above the offset.
// - Without segmentation each address result is taken modulo 65536.
// - No carry or overflow indication ever leaves an address sum.
// - Wrap applies to all indexed, relative, based and auto modes.
// - A segmented address is a 7-bit segment joined to a 16-bit offset.
// - A short 8-bit offset is zero-extended to 16 bits before use.
// - Segmented arithmetic touches only the offset, segment passes on.
// - An offset wrap never carries into the segment nor flags overflow.
// - Auto steps in segmented mode wrap inside the current segment.
// - With segmentation cleared by a load, the PC segment is used.
// - Segmented part with segmentation off uses 16-bit wrap rules.
// - I/O addresses are always 16-bit with modulo-65536 arithmetic.
// - An interrupt or trap start forces segmentation mode on.
`timescale 1ns/1ps
`include "aoa_cfg.svh"
module aoa_top #(
   parameter int OFS_W = `AOA_OFS_W,
   parameter int SEG_W = `AOA_SEG_W
) (
   input  wire logic               I_CLOCK,
   input  wire logic               I_RST_B,
   input  wire logic               I_REQ,
   input  wire aoa_pkg::aoa_mode_type  I_MODE,
   input  wire aoa_pkg::aoa_space_type I_SPACE,
   input  wire logic               I_SHORT,
   input  wire logic [SEG_W-1:0]   I_SEG,
   input  wire logic [OFS_W-1:0]   I_BASE,
   input  wire logic [OFS_W-1:0]   I_DISP,
   input  wire logic [SEG_W-1:0]   I_PC_SEG,
   input  wire logic [1:0]         I_STEP,
   input  wire logic               I_LOAD_PROGRAM_STATUS_INSTR,
   input  wire logic               I_LOAD_CONTROL_REGISTER_INSTR,
   input  wire logic               I_SEGM_VALUE,
   input  wire logic               I_TRAP_START,
   output logic                    O_VALID,
   output logic [`AOA_ADDR_W-1:0]  O_ADDR,
   output logic                    O_SEGMENTED,
   output logic                    O_SEGM_MODE
);
   typedef struct packed {
      logic                   valid;
      logic [`AOA_ADDR_W-1:0] addr;
      logic                   segmented;
      logic                   segm_mode;
   } aoa_st_type;
   aoa_st_type st;
   aoa_st_type next_st;
   logic       segm;
   logic [OFS_W-1:0] disp_ext;
   logic [SEG_W-1:0] seg_sel;
   aoa_add_if add_bus ();
   aoa_offset_adder u_adder (
      .bus (add_bus)
   );
   aoa_seg_ctl u_seg (
      .i_clk                         (I_CLOCK),
      .i_rst_b                       (I_RST_B),
      .i_load_program_status_instr   (I_LOAD_PROGRAM_STATUS_INSTR),
      .i_load_control_register_instr (I_LOAD_CONTROL_REGISTER_INSTR),
      .i_segm_value                  (I_SEGM_VALUE),
      .i_trap_start                  (I_TRAP_START),
      .o_segm                        (segm)
   );
   function automatic logic [OFS_W-1:0] step_size(input logic [1:0] s);
      step_size = {{(OFS_W-3){1'b0}}, 3'b001} << s;
   endfunction
   always_comb begin
      // Short offsets gain eight zero high bits first.
      if (I_SHORT) begin
         disp_ext = {{(OFS_W-`AOA_SHORT_W){1'b0}},
                     I_DISP[`AOA_SHORT_W-1:0]};
      end else begin
         disp_ext = I_DISP;
      end
      add_bus.op_a = I_BASE;
      add_bus.sub  = 1'b0;
      // All modes share the wrapping adder.
      case (I_MODE)
         aoa_pkg::AOA_MODE_AUTOINC: begin
            add_bus.op_b = step_size(I_STEP);
         end
         aoa_pkg::AOA_MODE_AUTODEC: begin
            add_bus.op_b = step_size(I_STEP);
            add_bus.sub  = 1'b1;
         end
         aoa_pkg::AOA_MODE_DIRECT: begin
            add_bus.op_a = disp_ext;
            add_bus.op_b = '0;
         end
         default: begin
            add_bus.op_b = disp_ext;
         end
      endcase
      // Without segmentation the PC segment is applied.
      if (segm) begin
         seg_sel = I_SEG;
      end else begin
         seg_sel = I_PC_SEG;
      end
   end
   always_comb begin
      next_st = st;
      next_st.valid = I_REQ;
      next_st.segm_mode = segm;
      if (I_REQ) begin
         if (I_SPACE == aoa_pkg::AOA_SPACE_IO) begin
            // I/O is never segmented.
            next_st.addr = {{SEG_W{1'b0}}, add_bus.sum};
            next_st.segmented = 1'b0;
         end else if (segm) begin
            next_st.addr = {seg_sel, add_bus.sum};
            next_st.segmented = 1'b1;
         end else begin
            // Offset alone, wrapped, tagged with PC segment.
            next_st.addr = {seg_sel, add_bus.sum};
            next_st.segmented = 1'b0;
         end
      end
   end
   always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         st.valid     <= 1'b0;
         st.addr      <= '0;
         st.segmented <= 1'b0;
         st.segm_mode <= `AOA_SEGM_RESET;
      end else begin
         st <= next_st;
      end
   end
   assign O_VALID     = st.valid;
   assign O_ADDR      = st.addr;
   assign O_SEGMENTED = st.segmented;
   assign O_SEGM_MODE = st.segm_mode;
endmodule

// ### dv/aoa_bus_model.sv
// Model of the memory address bus that takes each formed address.
// Assumes it shares the clock of the address unit.
`timescale 1ns/1ps
module aoa_bus_model (
   input  wire logic        i_clk,
   input  wire logic        i_valid,
   input  wire logic [22:0] i_addr,
   output logic [22:0]      o_last
);
   always_ff @(posedge i_clk) if (i_valid) o_last <= i_addr;
endmodule

// ### dv/aoa_chk.sv
// Assertions on the ports of the address offset arithmetic unit.
// Assumes it is bound into aoa_top and sees only its ports.
`timescale 1ns/1ps
module aoa_chk (
   input wire logic I_CLOCK, I_RST_B, I_REQ, I_SHORT, I_SEGM_VALUE,
   input wire aoa_pkg::aoa_mode_type I_MODE,
   input wire aoa_pkg::aoa_space_type I_SPACE,
   input wire logic [6:0] I_SEG, I_PC_SEG,
   input wire logic [15:0] I_BASE, I_DISP,
   input wire logic [1:0] I_STEP,
   input wire logic I_LOAD_PROGRAM_STATUS_INSTR,
   input wire logic I_LOAD_CONTROL_REGISTER_INSTR,
   input wire logic I_TRAP_START, O_VALID, O_SEGMENTED, O_SEGM_MODE,
   input wire logic [22:0] O_ADDR
);
   wire logic [15:0] dsp = I_SHORT ? {8'h00, I_DISP[7:0]} : I_DISP;
   wire logic [15:0] stp = 16'h0001 << I_STEP;
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RST_B);
   sequence mem_req;
      I_REQ && I_SPACE == aoa_pkg::AOA_SPACE_MEM;
   endsequence
   sequence flag_load;
      (I_LOAD_PROGRAM_STATUS_INSTR || I_LOAD_CONTROL_REGISTER_INSTR)
         && !I_TRAP_START;
   endsequence
   valid_pulse_a: assert property (
      I_REQ |=> O_VALID) else $error("valid missing");
   valid_drop_a: assert property (
      !I_REQ |=> !O_VALID) else $error("valid stuck");
   sum_wrap_a: assert property (
      I_REQ && I_MODE < aoa_pkg::AOA_MODE_AUTOINC
      |=> O_ADDR[15:0] == 16'($past(I_BASE) + $past(dsp)))
      else $error("sum wrong");
   auto_inc_a: assert property (
      I_REQ && I_MODE == aoa_pkg::AOA_MODE_AUTOINC
      |=> O_ADDR[15:0] == 16'($past(I_BASE) + $past(stp)))
      else $error("increment wrong");
   auto_dec_a: assert property (
      I_REQ && I_MODE == aoa_pkg::AOA_MODE_AUTODEC
      |=> O_ADDR[15:0] == 16'($past(I_BASE) - $past(stp)))
      else $error("decrement wrong");
   io_flat_a: assert property (
      I_REQ && I_SPACE == aoa_pkg::AOA_SPACE_IO
      |=> O_ADDR[22:16] == 7'h00 && !O_SEGMENTED) else $error("io address");
   seg_pick_a: assert property (
      mem_req |=> O_SEGMENTED == O_SEGM_MODE && O_ADDR[22:16] ==
      (O_SEGM_MODE ? $past(I_SEG) : $past(I_PC_SEG))) else $error("segment");
   trap_force_a: assert property (
      I_TRAP_START |-> ##2 O_SEGM_MODE) else $error("trap mode");
   flag_load_a: assert property (
      flag_load |-> ##2 O_SEGM_MODE == $past(I_SEGM_VALUE, 2))
      else $error("flag load");
endmodule
bind aoa_top aoa_chk u_chk (.*);

// ### dv/aoa_top_bench.sv
// Self-checking bench of the address offset arithmetic unit.
// Assumes the unit, its checker and the bus model are compiled first.
`timescale 1ns/1ps
module aoa_top_bench;
   logic clk = 1'b0, rst_b = 1'b0, req = 1'b0, shrt = 1'b0, lps = 1'b0;
   logic lcr = 1'b0, sv = 1'b0, trap = 1'b0, vld, segd, segm;
   logic [6:0] seg = 7'h55, pcs = 7'h2a;
   logic [15:0] base = 16'h0000, disp = 16'h0020;
   logic [1:0] step = 2'h0;
   logic [22:0] addr, last;
   aoa_pkg::aoa_mode_type mode = aoa_pkg::AOA_MODE_INDEXED;
   aoa_pkg::aoa_space_type spc = aoa_pkg::AOA_SPACE_MEM;
   int err_total = 0, samples_checked = 0;
   always #25 clk = ~clk;
   aoa_top DUT (.I_CLOCK(clk), .I_RST_B(rst_b), .I_REQ(req), .I_MODE(mode),
      .I_SPACE(spc), .I_SHORT(shrt), .I_SEG(seg), .I_BASE(base),
      .I_DISP(disp), .I_PC_SEG(pcs), .I_STEP(step),
      .I_LOAD_PROGRAM_STATUS_INSTR(lps), .I_LOAD_CONTROL_REGISTER_INSTR(lcr),
      .I_SEGM_VALUE(sv), .I_TRAP_START(trap), .O_VALID(vld), .O_ADDR(addr),
      .O_SEGMENTED(segd), .O_SEGM_MODE(segm));
   aoa_bus_model BUS (.i_clk(clk), .i_valid(vld), .i_addr(addr), .o_last(last));
   task chk(input logic [24:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // Expected value carries the segmented flag above the address.
   task issue(input int m, input logic [15:0] b, input logic [23:0] e);
      @(posedge clk) #1;
      req = 1'b1;
      mode = aoa_pkg::aoa_mode_type'(m);
      base = b;
      @(posedge clk) #1;
      req = 1'b0;
      chk({vld, segd, addr}, {1'b1, e});
   endtask
   task load(input logic p, c, v, t, x);
      @(posedge clk) #1;
      {lps, lcr, sv, trap} = {p, c, v, t};
      @(posedge clk) #1;
      {lps, lcr, trap} = 3'h0;
      repeat (2) @(posedge clk);
      #1 chk({24'h0, segm}, {24'h0, x});
   endtask
   task t_wrap;
      for (int i = 0; i < 4; i++) begin
         issue(i, 16'hfff0, {8'hd5, 16'h0010});
      end
   endtask
   task t_short_auto;
      shrt = 1'b1;
      disp = 16'hab90;
      issue(0, 16'hff80, {8'hd5, 16'h0010});
      issue(6, 16'hffff, {8'hd5, 16'h0090});
      shrt = 1'b0;
      disp = 16'h0020;
      for (int s = 0; s < 4; s++) begin
         step = 2'(s);
         issue(4, 16'hffff, {8'hd5, 16'((1 << s) - 1)});
         issue(5, 16'h0000, {8'hd5, 16'(-(1 << s))});
      end
   endtask
   task t_flat;
      load(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      issue(1, 16'hffff, {8'h2a, 16'h001f});
      load(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
      spc = aoa_pkg::AOA_SPACE_IO;
      issue(3, 16'hfff0, {8'h00, 16'h0010});
      spc = aoa_pkg::AOA_SPACE_MEM;
   endtask
   task t_trap;
      load(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      load(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
      issue(2, 16'h1234, {8'hd5, 16'h1254});
      @(posedge clk) #1;
      chk({2'h0, last}, {9'h055, 16'h1254});
   endtask
   task test_done;
      $display("Checks %0d, errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      #1 rst_b = 1'b1;
      t_wrap();
      t_short_auto();
      t_flat();
      t_trap();
      test_done();
   end
   initial begin
      #20000;
      err_total++;
      test_done();
   end
endmodule
